/* sim/exp_bus_peer.sv */
/*
  Peripheral model on the expansion bus: measures each command strobe.
  Assumes strobes are active low and one is active at a time.
*/
`timescale 1ns/100ps
module exp_bus_peer (
  input wire logic         mclk,
  input wire logic         rst,
  input wire logic         io_rd_n,
  input wire logic         io_wr_n,
  input wire logic         mem_rd_n,
  input wire logic         mem_wr_n,
  input wire logic         low_mem_read_strobe_n,
  output logic             obs_valid,
  output logic [12:0]      obs
);
  logic [3:0] act;
  logic [3:0] code_q;
  logic [7:0] cnt_q;
  logic       seen_q;
  assign act = ~{io_rd_n, io_wr_n, mem_rd_n, mem_wr_n};
  // Report strobe kind, width and read strobe use once released
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      obs_valid <= 1'b0;
      obs <= 13'h0000;
      cnt_q <= 8'h00;
      code_q <= 4'h0;
      seen_q <= 1'b0;
    end
    else
    begin
      obs_valid <= 1'b0;
      if (act != 4'h0)
      begin
        cnt_q <= cnt_q + 8'h01;
        code_q <= act;
        seen_q <= seen_q | ~low_mem_read_strobe_n;
      end
      else if (cnt_q != 8'h00)
      begin
        obs_valid <= 1'b1;
        obs <= {seen_q, code_q, cnt_q};
        cnt_q <= 8'h00;
        seen_q <= 1'b0;
      end
    end
endmodule : exp_bus_peer

/* sim/exp_bus_timing_props.sv */
/*
  Checker for the expansion bus cycle timing block.
  Assumes it is bound to exp_bus_timing and sees only its ports.
*/
`timescale 1ns/100ps
module exp_bus_timing_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        req_ready,
  input wire logic        cyc_done,
  input wire logic        exp_bus_clk,
  input wire logic        io_rd_n,
  input wire logic        io_wr_n,
  input wire logic        mem_rd_n,
  input wire logic        mem_wr_n,
  input wire logic        low_mem_read_strobe_n
);
  logic       any_low;
  logic [6:0] low_cnt_d;
  logic [6:0] low_cnt_q;
  assign any_low = ~&{io_rd_n, io_wr_n, mem_rd_n, mem_wr_n};
  always_comb low_cnt_d = any_low ? low_cnt_q + 7'h01 : 7'h00;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      low_cnt_q <= 7'h00;
    else
      low_cnt_q <= low_cnt_d;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_io_width: assert property ($rose(io_rd_n & io_wr_n) |-> low_cnt_q % 8 == 4 && low_cnt_q <= 68)
    else $error("io strobe width wrong");
  chk_mem_width: assert property ($rose(mem_rd_n & mem_wr_n) |-> low_cnt_q % 4 == 0 && low_cnt_q inside {[12:72]})
    else $error("memory strobe width wrong");
  chk_done_at_end: assert property ($rose(&{io_rd_n, io_wr_n, mem_rd_n, mem_wr_n}) |-> cyc_done)
    else $error("cycle end without done");
  chk_done_pulse: assert property (cyc_done |=> !cyc_done)
    else $error("done longer than one cycle");
  chk_ready_done: assert property (cyc_done |-> req_ready)
    else $error("not ready at cycle end");
  chk_busy_blocks: assert property (any_low |-> !req_ready)
    else $error("ready during a cycle");
  chk_strobe_rise: assert property ($fell(&{io_rd_n, io_wr_n, mem_rd_n, mem_wr_n}) |-> $rose(exp_bus_clk))
    else $error("strobe not on bus clock rise");
  chk_clk_high: assert property ($rose(exp_bus_clk) |-> exp_bus_clk [*4] ##1 !exp_bus_clk)
    else $error("bus clock high phase wrong");
  chk_low_strobe: assert property (!low_mem_read_strobe_n |-> !mem_rd_n)
    else $error("low memory strobe without read");
  chk_one_cmd: assert property ($onehot0(~{io_rd_n, io_wr_n, mem_rd_n, mem_wr_n}))
    else $error("two command strobes active");
endmodule : exp_bus_timing_props

bind exp_bus_timing exp_bus_timing_props u_props (.mclk, .rst, .req_ready, .cyc_done, .exp_bus_clk, .io_rd_n,
  .io_wr_n, .mem_rd_n, .mem_wr_n, .low_mem_read_strobe_n);

/* sim/expansion_bus_cycle_timing_tb_top.sv */
/*
  Self-checking bench of the expansion bus cycle timing block.
  Assumes the checker is bound and the peer model measures strobes.
*/
`timescale 1ns/100ps
module expansion_bus_cycle_timing_tb_top;
  import exp_bus_pkg::*;
  localparam logic [11:0] A_MODE = {2'b00, MODE_IDX, 2'b00};
  localparam logic [11:0] A_IO   = {2'b00, IO_WAIT_IDX, 2'b00};
  localparam logic [11:0] A_MEM  = {2'b00, MEM_WAIT_IDX, 2'b00};
  localparam logic [11:0] A_NONE = 12'h0E0;
  logic mclk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, req_valid, req_ready, cyc_done, exp_bus_clk;
  logic io_rd_n, io_wr_n, mem_rd_n, mem_wr_n, low_mem_read_strobe_n, rom_chip_enable_0_n, rom_chip_enable_1_n;
  logic              obs_valid;
  logic [12:0]       obs;
  logic [11:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, cur_ld;
  logic [2:0]        cur_wi, cur_w8, cur_w16;
  logic              cur_inh;
  bus_req_t          req;
  logic [33:0]       exp_r[$], exp_b[$], exp_c[$];
  int                mismatches, samples_checked;
  exp_bus_timing dut (.mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .req_valid, .req_ready, .req,
    .cyc_done, .exp_bus_clk, .io_rd_n, .io_wr_n, .mem_rd_n, .mem_wr_n, .low_mem_read_strobe_n,
    .rom_chip_enable_0_n, .rom_chip_enable_1_n);
  exp_bus_peer peer (.mclk, .rst, .io_rd_n, .io_wr_n, .mem_rd_n, .mem_wr_n, .low_mem_read_strobe_n, .obs_valid, .obs);
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic results;
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  task automatic hang;
    mismatches++;
    results();
  endtask : hang
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    exp_b.push_back({e, 32'h00000000});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (!s_axi_bvalid && n < 100);
    if (n >= 100) hang();
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] e);
    int n;
    exp_r.push_back({e, 24'h000000, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (!s_axi_rvalid && n < 100);
    if (n >= 100) hang();
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : axi_rd
  task automatic setup(input logic [1:0] m, input logic [1:0] ld, input logic inh, input logic [8:0] w);
    {cur_ld, cur_inh, cur_wi, cur_w8, cur_w16} = {ld, inh, w};
    axi_wr(A_MODE, {m, ld, inh, 3'h0}, RESP_OKAY);
    axi_wr(A_IO, {1'b0, w[8:6], 4'h0}, RESP_OKAY);
    axi_wr(A_MEM, {1'b0, w[5:3], 1'b0, w[2:0]}, RESP_OKAY);
  endtask : setup
  task automatic bus_cyc(input bus_req_t r, input logic lat);
    int n, w;
    logic [3:0] c;
    logic [1:0] ce;
    w = 4 * (r.kind[1] ? 4 + 2 * cur_w16 : 3 + 2 * (r.kind == CYC_IO ? cur_wi : cur_w8));
    c = (r.kind == CYC_IO) ? (r.write ? 4'h4 : 4'h8) : (r.write ? 4'h1 : 4'h2);
    exp_c.push_back({21'h000000, r.kind != CYC_IO && !r.write && !(cur_inh && r.rom_hit != 2'b00), c, w[7:0]});
    req <= r;
    req_valid <= 1'b1;
    n = 0;
    do @(posedge mclk); while (!req_ready && ++n < 100);
    if (n >= 100) hang();
    req_valid <= 1'b0;
    n = 0;
    ce = 2'b00;
    do
    begin
      @(posedge mclk);
      ce = ce | ~{rom_chip_enable_1_n, rom_chip_enable_0_n};
    end
    while (!cyc_done && ++n < 300);
    if (n >= 300) hang();
    if (lat) cmp(34'(n + 1), 34'(2 + cur_ld + w));
    cmp(34'(ce), 34'(r.kind != CYC_IO ? r.rom_hit : 2'b00));
  endtask : bus_cyc
  task automatic rises(input int want);
    int n;
    n = 0;
    repeat (32)
    begin
      @(posedge mclk);
      if (exp_bus_clk === 1'b1) n++;
    end
    cmp(34'(n), 34'(want));
  endtask : rises
  always @(posedge mclk)
  begin
    if (s_axi_bvalid && s_axi_bready) cmp({s_axi_bresp, 32'h00000000}, exp_b.pop_front());
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (obs_valid) cmp({21'h000000, obs}, exp_c.pop_front());
  end
  initial
  begin
    {rst, req_valid, req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 12'h800;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    s_axi_wstrb = 4'hF;
    {cur_ld, cur_inh, cur_wi, cur_w8, cur_w16} = 12'h124;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'h77E21A50));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    axi_rd(A_MODE, 8'h00, RESP_OKAY);
    axi_rd(A_IO, 8'h40, RESP_OKAY);
    axi_rd(A_MEM, 8'h44, RESP_OKAY);
    for (int k = 0; k < 3; k++) bus_cyc({cyc_kind_t'(k), 3'b000}, 1'b1);
    axi_wr(A_IO, 8'hFF, RESP_OKAY);
    axi_rd(A_IO, 8'h70, RESP_OKAY);
    axi_wr(A_NONE, 8'h11, RESP_SLVERR);
    axi_rd(A_NONE, 8'h00, RESP_SLVERR);
    setup(2'b00, 2'b11, 1'b0, 9'h000);
    rises(0);
    for (int k = 0; k < 3; k++) bus_cyc({cyc_kind_t'(k), 3'b000}, 1'b1);
    axi_wr(A_MODE, 8'hC0, RESP_OKAY);
    axi_rd(A_MODE, 8'hC0, RESP_OKAY);
    cur_ld = 2'b00;
    rises(0);
    bus_cyc({CYC_IO, 3'b000}, 1'b1);
    setup(2'b01, 2'b00, 1'b1, 9'h000);
    rises(16);
    setup(2'b00, 2'b00, 1'b0, 9'h000);
    fork
      bus_cyc({CYC_IO, 3'b000}, 1'b1);
      begin
        repeat (4) @(posedge mclk);
        axi_wr(A_IO, 8'h70, RESP_OKAY);
      end
    join
    cur_wi = 3'h7;
    bus_cyc({CYC_IO, 3'b100}, 1'b1);
    for (int i = 0; i < 24; i++)
    begin
      rv = $urandom;
      setup(2'(i % 3), rv[1:0], rv[2], rv[11:3]);
      bus_cyc(bus_req_t'(rv[16:12]), i % 3 == 0);
    end
    repeat (4) @(posedge mclk);
    cmp(34'(exp_b.size() + exp_r.size() + exp_c.size()), 34'h0);
    results();
  end
endmodule : expansion_bus_cycle_timing_tb_top

/* src/exp_bus_pkg.sv */
/*
  Constants and types of the expansion bus cycle timing block.
  Assumes a 50 MHz processor clock and AXI4-Lite register access.
*/
package exp_bus_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] MODE_IDX = 8'h34;
  localparam logic [7:0] IO_WAIT_IDX = 8'h35;
  localparam logic [7:0] MEM_WAIT_IDX = 8'h36;
  localparam logic [7:0] STATUS_IDX = 8'h37;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IO_WAIT_RST = 8'h40;
  localparam logic [7:0] MEM_WAIT_RST = 8'h44;
  localparam logic [7:0] MODE_MASK = 8'hF8;
  localparam logic [7:0] IO_WAIT_MASK = 8'h70;
  localparam logic [7:0] MEM_WAIT_MASK = 8'h77;
  localparam int unsigned CLK_MODE_LSB = 6;
  localparam int unsigned LEAD_LSB = 4;
  localparam int unsigned ROM_INH_BIT = 3;
  localparam int unsigned IO_W_LSB = 4;
  localparam int unsigned MEM8_WAIT_COUNT_LSB = 4;
  localparam int unsigned MEM16_WAIT_COUNT_LSB = 0;
  localparam int unsigned MCLK_PERIOD_NS = 20;
  localparam int unsigned BUS_CLK_PERIOD_NS = 160;
  localparam int unsigned HALF_CYC = BUS_CLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam logic [4:0] HALVES_NARROW = 5'h03;
  localparam logic [4:0] HALVES_WIDE = 5'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CLK_STOP    = 2'b00,
    CLK_SYNC    = 2'b01,
    CLK_STRETCH = 2'b10,
    CLK_RSVD    = 2'b11
  } clk_mode_t;

  typedef enum logic [1:0] {
    CYC_IO    = 2'b00,
    CYC_MEM8  = 2'b01,
    CYC_MEM16 = 2'b10,
    CYC_BAD   = 2'b11
  } cyc_kind_t;

  typedef struct packed {
    cyc_kind_t  kind;
    logic       write;
    logic [1:0] rom_hit;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LEAD  = 2'b01,
    ST_ALIGN = 2'b10,
    ST_CMD   = 2'b11
  } cyc_state_t;
endpackage : exp_bus_pkg

/* src/exp_bus_timing.sv */
/*
  Expansion bus cycle timing: bus clock generation, lead-off delay,
  wait states and command strobes, with AXI4-Lite registers.
  Assumes requests come from logic on mclk; all strobes active low.
*/
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps

module exp_bus_timing (
  input  wire logic                           mclk,
  input  wire logic                           rst,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [exp_bus_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [exp_bus_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  input  wire logic                           req_valid,
  output logic                                req_ready,
  input  wire exp_bus_pkg::bus_req_t          req,
  output logic                                cyc_done,
  output logic                                exp_bus_clk,
  output logic                                io_rd_n,
  output logic                                io_wr_n,
  output logic                                mem_rd_n,
  output logic                                mem_wr_n,
  output logic                                low_mem_read_strobe_n,
  output logic                                rom_chip_enable_0_n,
  output logic                                rom_chip_enable_1_n
);
  import exp_bus_pkg::*;

  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0]        wdata_q, wdata_d;
  logic              wstrb_q, wstrb_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0]        rdata_q, rdata_d;
  logic [7:0]        mode_q, mode_d, io_wait_q, io_wait_d;
  logic [7:0]        mem_wait_q, mem_wait_d;
  logic [7:0]        status;

  cyc_state_t        st_q, st_d;
  clk_mode_t         act_mode_q, act_mode_d;
  bus_req_t          cur_q, cur_d;
  logic              clk_q, clk_d;
  logic [7:0]        ph_q, ph_d;
  logic [4:0]        hc_q, hc_d, tgt_q, tgt_d;
  logic [1:0]        lead_q, lead_d;
  logic              inh_q, inh_d;
  logic              ready_q, ready_d, done_q, done_d;
  logic              io_rd_q, io_rd_d, io_wr_q, io_wr_d;
  logic              mem_rd_q, mem_rd_d, mem_wr_q, mem_wr_d;
  logic              lmr_q, lmr_d, ce0_q, ce0_d, ce1_q, ce1_d;
  logic              tick;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[ADDR_W-1:10] == '0) && (a[9:2] == idx);
  endfunction : hit

  assign tick = (ph_q == 8'(HALF_CYC - 1));
  assign status = {4'h0, clk_q, act_mode_q, (st_q != ST_IDLE)};

  // Register bus
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    mode_d = mode_q;
    io_wait_d = io_wait_q;
    mem_wait_d = mem_wait_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata[7:0];
      wstrb_d = s_axi_wstrb[0];
    end
    if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (aw_have_q && w_have_q && !bvalid_q)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (hit(awaddr_q, MODE_IDX))
      begin
        if (wstrb_q)
          mode_d = wdata_q & MODE_MASK;
      end
      else if (hit(awaddr_q, IO_WAIT_IDX))
      begin
        if (wstrb_q)
          io_wait_d = wdata_q & IO_WAIT_MASK;
      end
      else if (hit(awaddr_q, MEM_WAIT_IDX))
      begin
        if (wstrb_q)
          mem_wait_d = wdata_q & MEM_WAIT_MASK;
      end
      else if (!hit(awaddr_q, STATUS_IDX))
        bresp_d = RESP_SLVERR;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      if (hit(s_axi_araddr, MODE_IDX))
        rdata_d = mode_q;
      else if (hit(s_axi_araddr, IO_WAIT_IDX))
        rdata_d = io_wait_q;
      else if (hit(s_axi_araddr, MEM_WAIT_IDX))
        rdata_d = mem_wait_q;
      else if (hit(s_axi_araddr, STATUS_IDX))
        rdata_d = status;
      else
      begin
        rdata_d = 8'h00;
        rresp_d = RESP_SLVERR;
      end
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 8'h00;
      mode_q <= MODE_RST;
      io_wait_q <= IO_WAIT_RST;
      mem_wait_q <= MEM_WAIT_RST;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      mode_q <= mode_d;
      io_wait_q <= io_wait_d;
      mem_wait_q <= mem_wait_d;
    end
  end

  // Bus clock and cycle sequencing
  always_comb
  begin
    st_d = st_q;
    act_mode_d = act_mode_q;
    cur_d = cur_q;
    clk_d = clk_q;
    ph_d = ph_q;
    hc_d = hc_q;
    tgt_d = tgt_q;
    lead_d = lead_q;
    inh_d = inh_q;
    ready_d = ready_q;
    done_d = 1'b0;
    io_rd_d = io_rd_q;
    io_wr_d = io_wr_q;
    mem_rd_d = mem_rd_q;
    mem_wr_d = mem_wr_q;
    lmr_d = lmr_q;
    ce0_d = ce0_q;
    ce1_d = ce1_q;
    if (act_mode_q == CLK_SYNC || act_mode_q == CLK_STRETCH || st_q == ST_CMD || clk_q)
    begin
      if (act_mode_q == CLK_STRETCH && st_q == ST_LEAD && !clk_q && tick)
        ph_d = ph_q;
      else if (tick)
      begin
        ph_d = 8'h00;
        clk_d = !clk_q;
      end
      else
        ph_d = ph_q + 8'h01;
    end
    else
      ph_d = 8'h00;
    unique case (st_q)
      ST_IDLE:
      begin
        act_mode_d = (mode_q[CLK_MODE_LSB +: 2] == CLK_RSVD) ? CLK_STOP
                                                             : clk_mode_t'(mode_q[CLK_MODE_LSB +: 2]);
        if (req_valid && ready_q)
        begin
          ready_d = 1'b0;
          cur_d = req;
          lead_d = mode_q[LEAD_LSB +: 2];
          inh_d = mode_q[ROM_INH_BIT];
          if (req.kind == CYC_IO)
            tgt_d = HALVES_NARROW + {1'b0, io_wait_q[IO_W_LSB +: 3], 1'b0};
          else if (req.kind == CYC_MEM8)
            tgt_d = HALVES_NARROW + {1'b0, mem_wait_q[MEM8_WAIT_COUNT_LSB +: 3], 1'b0};
          else
            tgt_d = HALVES_WIDE + {1'b0, mem_wait_q[MEM16_WAIT_COUNT_LSB +: 3], 1'b0};
          st_d = (mode_q[LEAD_LSB +: 2] == 2'b00) ? ST_ALIGN : ST_LEAD;
        end
        else
          ready_d = 1'b1;
      end
      ST_LEAD:
      begin
        lead_d = lead_q - 2'b01;
        if (lead_q == 2'b01)
          st_d = ST_ALIGN;
      end
      ST_ALIGN:
      begin
        if (!clk_q && (act_mode_q == CLK_STOP || tick))
        begin
          clk_d = 1'b1;
          ph_d = 8'h00;
          hc_d = 5'h00;
          st_d = ST_CMD;
          io_rd_d = (cur_q.kind == CYC_IO) && !cur_q.write;
          io_wr_d = (cur_q.kind == CYC_IO) && cur_q.write;
          mem_rd_d = (cur_q.kind != CYC_IO) && !cur_q.write;
          mem_wr_d = (cur_q.kind != CYC_IO) && cur_q.write;
          lmr_d = (cur_q.kind != CYC_IO) && !cur_q.write && (cur_q.rom_hit == 2'b00 || !inh_q);
          ce0_d = (cur_q.kind != CYC_IO) && cur_q.rom_hit[0];
          ce1_d = (cur_q.kind != CYC_IO) && cur_q.rom_hit[1];
        end
      end
      ST_CMD:
      begin
        if (tick)
        begin
          hc_d = hc_q + 5'h01;
          if (hc_q + 5'h01 == tgt_q)
          begin
            st_d = ST_IDLE;
            ready_d = 1'b1;
            done_d = 1'b1;
            io_rd_d = 1'b0;
            io_wr_d = 1'b0;
            mem_rd_d = 1'b0;
            mem_wr_d = 1'b0;
            lmr_d = 1'b0;
            ce0_d = 1'b0;
            ce1_d = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_IDLE;
      act_mode_q <= CLK_STOP;
      cur_q <= '0;
      clk_q <= 1'b0;
      ph_q <= 8'h00;
      hc_q <= 5'h00;
      tgt_q <= 5'h00;
      lead_q <= 2'b00;
      inh_q <= 1'b0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
      io_rd_q <= 1'b0;
      io_wr_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      lmr_q <= 1'b0;
      ce0_q <= 1'b0;
      ce1_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      act_mode_q <= act_mode_d;
      cur_q <= cur_d;
      clk_q <= clk_d;
      ph_q <= ph_d;
      hc_q <= hc_d;
      tgt_q <= tgt_d;
      lead_q <= lead_d;
      inh_q <= inh_d;
      ready_q <= ready_d;
      done_q <= done_d;
      io_rd_q <= io_rd_d;
      io_wr_q <= io_wr_d;
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      lmr_q <= lmr_d;
      ce0_q <= ce0_d;
      ce1_q <= ce1_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign req_ready = ready_q;
  assign cyc_done = done_q;
  assign exp_bus_clk = clk_q;
  assign io_rd_n = !io_rd_q;
  assign io_wr_n = !io_wr_q;
  assign mem_rd_n = !mem_rd_q;
  assign mem_wr_n = !mem_wr_q;
  assign low_mem_read_strobe_n = !lmr_q;
  assign rom_chip_enable_0_n = !ce0_q;
  assign rom_chip_enable_1_n = !ce1_q;
endmodule : exp_bus_timing
